/* File: led_ctrl_pkg.sv */
// Constants shared by the LED driver mode and fault flag control.
// Assumes a 10 MHz ref_clk; all times are converted to cycle counts here.
package led_ctrl_pkg;
    // =====================================================
    // Clock and times
    localparam int CLK_HZ = 10000000;
    localparam int DIM_WAKE_US = 15;
    localparam int PG_VALID_US = 70;
    // Least wait rounds up
    localparam int DIM_WAKE_CYC = (DIM_WAKE_US * CLK_HZ + 999999) / 1000000;
    // Longest time rounds down
    localparam int PG_VALID_CYC = (PG_VALID_US * CLK_HZ) / 1000000;
    // Pin-to-count latency of the power-good path: three flops, filter, first count edge
    localparam int PG_SYNC_CYC = 5;
    localparam int NUM_CH = 12;
    // =====================================================
    // Fault flag source selection
    localparam logic [1:0] FLG_SRC_ERR = 2'h0;
    localparam logic [1:0] FLG_SRC_OT = 2'h1;
    localparam logic [1:0] FLG_SRC_BOTH = 2'h2;
    // Reset values
    localparam logic [11:0] CH_EN_RST = 12'h000;
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_STANDALONE = 2'b01,
        PWR_BUS = 2'b10
    } pwr_mode_t;
endpackage

/* File: pin_sync.sv */
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Pin and result
    input wire logic pin,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // =====================================================
    // Stage chain; first flop read only by the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // Change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            level <= 1'b0;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end
endmodule
`default_nettype wire

/* File: led_driver_mode_and_fault_flag_control.sv */
// Mode, output gating and wired-OR fault flag logic of a 12-channel LED driver.
// Assumes comparator levels arrive asynchronously; bus protocol and OTP sit elsewhere.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// [RQ1] Digital supply falling below threshold forces standalone mode automatically.
// [RQ2] Digital supply alone keeps the bus interface alive for register writes.
// [RQ3] With low-impedance analog pin, interface starts at first analog rising edge.
// [RQ4] Standalone: select pin low picks image A, high picks image B.
// [RQ5] Global dimming input gates all enabled channels together.
// [RQ6] Channels wait 15 us after each dimming rising edge before turning on.
// [RQ7] External source holds each dimming high level longer than 20 us.
// [RQ8] Twelve channels, each with its own enable.
// [RQ9] Fault line driven high on open output, thermal shutdown or resistor short.
// [RQ10] Fault line reports errors, overtemperature or both, as configured.
// [RQ11] Global dimming fault: fault line pulses with dimming input.
// [RQ12] Register dimming fault in bus mode: fault line steadily high.
// [RQ13] Fault sensed from another driver handled as configuration directs.
// [RQ14] Pull-up source is digital supply when present, else internal regulator.
// [RQ15] Error detection valid within 70 us of power-good rising.
// [RQ16] Chip-select used only for one-time programming addressing.
// [RQ17] Each standalone image holds an on/off bit per channel.
// [RQ18] Bus-mode force bit moves device from standalone into bus mode.
// [RQ19] Comparator, power-good, select, dimming and fault inputs are synchronised; analog_supply_ok and analog_low_impedance are used unsynchronised.
// [RQ20] Error detection waits for qualified power-good.
module led_driver_mode_and_fault_flag_control
    import led_ctrl_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Supply comparators
    input wire logic digital_supply_ok,
    input wire logic analog_supply_ok,
    input wire logic analog_low_impedance,
    // Pins
    input wire logic config_select_pin,
    input wire logic global_dimming_in,
    input wire logic power_good_in,
    input wire logic chip_select_in,
    // Stored images and bus-side settings
    input wire logic [CH-1:0] standalone_image_a,
    input wire logic [CH-1:0] standalone_image_b,
    input wire logic [CH-1:0] bus_channel_enable,
    input wire logic [CH-1:0] bus_channel_pwm,
    input wire logic bus_mode_force_bit,
    input wire logic global_dimming_enable,
    input wire logic [1:0] flag_source_sel,
    input wire logic ext_fault_shutdown_en,
    // Fault detectors
    input wire logic [CH-1:0] open_detect,
    input wire logic thermal_shutdown,
    input wire logic overtemp_warn,
    input wire logic current_set_resistor_short,
    // Fault line, open-drain style high-side drive
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe,
    output logic pullup_from_digital_supply,
    // Status and channel drive
    output logic bus_if_enable,
    output logic otp_program_select,
    output logic error_detect_enable,
    output logic ext_fault_seen,
    output logic [1:0] pwr_mode,
    output logic [CH-1:0] channel_output
);
    pwr_mode_t mode_r;
    logic digital_supply_s;
    logic pg_s;
    logic sel_s;
    logic dim_s;
    logic flg_s;
    logic dim_d_r;
    logic [7:0] wake_cnt_r;
    logic dim_on_r;
    logic [9:0] pg_cnt_r;
    logic pg_ok_r;
    logic ana_d_r;
    logic if_start_r;
    logic ch_fault;
    logic err_flag;
    logic flag_req;
    logic [CH-1:0] ch_en;
    logic [CH-1:0] ch_nxt;
    logic [4:0] oe_hist_r;
    // =====================================================
    // Input synchronisers [RQ19]
    pin_sync u_digital_supply (.ref_clk(ref_clk), .resetn(resetn), .pin(digital_supply_ok), .level(digital_supply_s));
    pin_sync u_pg (.ref_clk(ref_clk), .resetn(resetn), .pin(power_good_in), .level(pg_s));
    pin_sync u_sel (.ref_clk(ref_clk), .resetn(resetn), .pin(config_select_pin), .level(sel_s));
    pin_sync u_dim (.ref_clk(ref_clk), .resetn(resetn), .pin(global_dimming_in), .level(dim_s));
    pin_sync u_flg (.ref_clk(ref_clk), .resetn(resetn), .pin(fault_line_in), .level(flg_s));
    // =====================================================
    // Interface start: immediate unless analog pin loads it to ground
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ana_d_r <= 1'b0;
            if_start_r <= 1'b0;
        end else begin
            ana_d_r <= analog_supply_ok;
            if (!analog_low_impedance) begin
                if_start_r <= 1'b1; // Digital supply alone is enough [RQ2]
            end else if (analog_supply_ok && !ana_d_r) begin
                if_start_r <= 1'b1; // First analog rising edge [RQ3]
            end
        end
    end
    assign bus_if_enable = if_start_r && digital_supply_s; // [RQ2]
    // Chip-select only steers programming addressing
    assign otp_program_select = chip_select_in; // [RQ16]
    // =====================================================
    // Operating mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= PWR_OFF;
        end else begin
            case (mode_r)
                PWR_OFF: begin
                    mode_r <= PWR_STANDALONE;
                end
                PWR_STANDALONE: begin
                    if (digital_supply_s && bus_mode_force_bit) begin
                        mode_r <= PWR_BUS; // [RQ18]
                    end
                end
                PWR_BUS: begin
                    if (!digital_supply_s) begin
                        mode_r <= PWR_STANDALONE; // No command needed [RQ1]
                    end
                end
                default: begin
                    mode_r <= PWR_STANDALONE;
                end
            endcase
        end
    end
    assign pwr_mode = mode_r;
    // =====================================================
    // Dimming wake-up delay; short highs never light the outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dim_d_r <= 1'b0;
            wake_cnt_r <= 8'h00;
            dim_on_r <= 1'b0;
        end else begin
            dim_d_r <= dim_s;
            if (!dim_s) begin
                wake_cnt_r <= 8'h00;
                dim_on_r <= 1'b0;
            end else if (!dim_d_r) begin
                wake_cnt_r <= 8'h01;
            end else if (!dim_on_r) begin
                if (wake_cnt_r >= 8'(DIM_WAKE_CYC - 1)) begin
                    dim_on_r <= 1'b1; // [RQ6]
                end
                wake_cnt_r <= wake_cnt_r + 8'h01;
            end
        end
    end
    // =====================================================
    // Power-good qualification before error detection
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pg_cnt_r <= 10'h000;
            pg_ok_r <= 1'b0;
        end else if (!pg_s) begin
            pg_cnt_r <= 10'h000;
            pg_ok_r <= 1'b0; // [RQ20]
        end else if (!pg_ok_r) begin
            // Sync latency eats into the budget, hence the shortened count
            if (pg_cnt_r >= 10'(PG_VALID_CYC - PG_SYNC_CYC)) begin
                pg_ok_r <= 1'b1; // [RQ15]
            end
            pg_cnt_r <= pg_cnt_r + 10'h001;
        end
    end
    assign error_detect_enable = pg_ok_r;
    // =====================================================
    // Channel enables and gating, one slice per channel
    assign ch_en = (mode_r == PWR_BUS) ? bus_channel_enable
                 : (sel_s ? standalone_image_b : standalone_image_a); // [RQ4] [RQ17]
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_ch
            always_comb begin
                ch_nxt[gi] = ch_en[gi]; // Own enable per channel [RQ8]
                if (mode_r == PWR_OFF) begin
                    ch_nxt[gi] = 1'b0;
                end else if (global_dimming_enable && !(dim_on_r && dim_s)) begin
                    ch_nxt[gi] = 1'b0; // All channels follow dimming [RQ5]
                end else if (mode_r == PWR_BUS && !global_dimming_enable) begin
                    ch_nxt[gi] = ch_en[gi] && bus_channel_pwm[gi];
                end
                if (thermal_shutdown || (ext_fault_shutdown_en && ext_fault_seen)) begin
                    ch_nxt[gi] = 1'b0; // [RQ13]
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            channel_output <= CH_EN_RST;
        end else begin
            channel_output <= ch_nxt;
        end
    end
    // =====================================================
    // Fault flag generation
    assign ch_fault = pg_ok_r && (|(open_detect & ch_en)); // [RQ9]
    // Under global dimming opens are only valid while channels conduct
    assign err_flag = (ch_fault && (!global_dimming_enable || dim_on_r)) // [RQ11] [RQ12]
                   || thermal_shutdown || current_set_resistor_short; // [RQ9]
    always_comb begin
        case (flag_source_sel)
            FLG_SRC_ERR: flag_req = err_flag; // [RQ10]
            FLG_SRC_OT: flag_req = overtemp_warn;
            FLG_SRC_BOTH: flag_req = err_flag || overtemp_warn;
            default: flag_req = err_flag;
        endcase
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fault_line_out <= 1'b0;
            fault_line_oe <= 1'b0;
            pullup_from_digital_supply <= 1'b0;
            ext_fault_seen <= 1'b0;
            oe_hist_r <= 5'h00;
        end else begin
            fault_line_out <= flag_req;
            fault_line_oe <= flag_req; // High-side only drives while flagging
            pullup_from_digital_supply <= digital_supply_s; // [RQ14]
            // Own drive, and its echo still inside the synchroniser, masks sensing
            oe_hist_r <= {oe_hist_r[3:0], fault_line_oe};
            ext_fault_seen <= flg_s && !fault_line_oe && !(|oe_hist_r); // [RQ13]
        end
    end
    // =====================================================
    // Assertions
    sequence s_dim_rise;
        $rose(dim_s);
    endsequence
    property p_wake;
        @(posedge ref_clk) disable iff (!resetn)
        s_dim_rise ##1 dim_s[*8] |-> !dim_on_r;
    endproperty
    a_wake: assert property (p_wake) else $error("channels woke too early"); // [RQ6]
    property p_sam_on_loss;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_r == PWR_BUS && !digital_supply_s) |=> mode_r == PWR_STANDALONE;
    endproperty
    a_sam_on_loss: assert property (p_sam_on_loss) else $error("no fallback to standalone"); // [RQ1]
    property p_force;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_r == PWR_STANDALONE && digital_supply_s && bus_mode_force_bit) |=> mode_r == PWR_BUS;
    endproperty
    a_force: assert property (p_force) else $error("force bit ignored"); // [RQ18]
    property p_image;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_r == PWR_STANDALONE && !global_dimming_enable && !thermal_shutdown
         && !(ext_fault_shutdown_en && ext_fault_seen))
        |=> channel_output == $past(sel_s ? standalone_image_b : standalone_image_a);
    endproperty
    a_image: assert property (p_image) else $error("wrong standalone image"); // [RQ4]
    property p_dim_off;
        @(posedge ref_clk) disable iff (!resetn)
        (global_dimming_enable && !dim_s) |=> channel_output == '0;
    endproperty
    a_dim_off: assert property (p_dim_off) else $error("channel lit while dimmed off"); // [RQ5]
    property p_pg;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(pg_s) ##1 pg_s[*8] |-> !pg_ok_r;
    endproperty
    a_pg: assert property (p_pg) else $error("error detection enabled too soon"); // [RQ20]
    property p_pg_valid;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(pg_s) |-> ##[1:700] (pg_ok_r || !pg_s);
    endproperty
    a_pg_valid: assert property (p_pg_valid) else $error("detection not valid in time"); // [RQ15]
    property p_tsd_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (thermal_shutdown && flag_source_sel != FLG_SRC_OT) |=> fault_line_out && fault_line_oe;
    endproperty
    a_tsd_flag: assert property (p_tsd_flag) else $error("fault line not driven"); // [RQ9]
    property p_pullup;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> pullup_from_digital_supply == $past(digital_supply_s);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up source wrong"); // [RQ14]
    property p_steady;
        @(posedge ref_clk) disable iff (!resetn)
        (ch_fault && !global_dimming_enable && flag_source_sel == FLG_SRC_ERR) |=> fault_line_out;
    endproperty
    a_steady: assert property (p_steady) else $error("fault line not steady"); // [RQ12]
endmodule
`default_nettype wire

/* File: fault_partner.sv */
// Far-side model: wired-OR fault line with pull-down, plus a global dimming source.
// Assumes the bench drives other_drive and dim_start at the falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module fault_partner #(
    parameter int HIGH_CYC = 250
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Fault line parties
    input wire logic dut_out,
    input wire logic dut_oe,
    input wire logic other_drive,
    output logic line,
    // Dimming source
    input wire logic dim_start,
    output logic dim_out
);
    // =====================================================
    // Wired-OR line
    int cnt_r;
    // Released line falls to the pull-down, never holds the old value
    assign line = (dut_oe & dut_out) | other_drive;
    // =====================================================
    // Dimming pulse, 25 us high so the wake delay leaves real on-time
    // Counts on rising edges, clear of the bench's falling-edge writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 0;
        end else if (dim_start && cnt_r == 0) begin
            cnt_r <= HIGH_CYC;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    assign dim_out = (cnt_r != 0);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the LED driver mode and fault flag control.
// Assumes fault_partner models the far side; stimulus changes at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import led_ctrl_pkg::*;
    typedef struct {string name; logic [11:0] exp; int sel;} note_t;
    // =====================================================
    // Signals
    logic ref_clk = 1'b0, resetn = 1'b0;
    logic dsok = 1'b0, aok = 1'b1, alowz = 1'b0, cfg = 1'b0, pg = 1'b0, cs = 1'b0;
    logic [11:0] img_a = 12'h000, img_b = 12'h000, en = 12'h000, pwm = 12'hfff, open = 12'h000;
    logic force_b = 1'b0, gde = 1'b0, xsd = 1'b0, tsd = 1'b0, otw = 1'b0, rsh = 1'b0;
    logic [1:0] fsel = 2'h0;
    logic other = 1'b0, dim_start = 1'b0, line, dim, f_out, f_oe, pu, bus_if, otp, ede, xseen;
    logic [1:0] mode;
    logic [11:0] ch;
    logic [31:0] rnd = 32'd73253;
    int fails = 0, tests_run = 0;
    note_t notes[$];
    always #50 ref_clk = ~ref_clk;
    led_driver_mode_and_fault_flag_control dut (.ref_clk(ref_clk), .resetn(resetn),
        .digital_supply_ok(dsok), .analog_supply_ok(aok), .analog_low_impedance(alowz),
        .config_select_pin(cfg), .global_dimming_in(dim), .power_good_in(pg),
        .chip_select_in(cs), .standalone_image_a(img_a), .standalone_image_b(img_b),
        .bus_channel_enable(en), .bus_channel_pwm(pwm), .bus_mode_force_bit(force_b),
        .global_dimming_enable(gde), .flag_source_sel(fsel), .ext_fault_shutdown_en(xsd),
        .open_detect(open), .thermal_shutdown(tsd), .overtemp_warn(otw),
        .current_set_resistor_short(rsh), .fault_line_in(line), .fault_line_out(f_out),
        .fault_line_oe(f_oe), .pullup_from_digital_supply(pu), .bus_if_enable(bus_if),
        .otp_program_select(otp), .error_detect_enable(ede), .ext_fault_seen(xseen),
        .pwr_mode(mode), .channel_output(ch));
    fault_partner #(.HIGH_CYC(250)) partner (.ref_clk(ref_clk), .resetn(resetn),
        .dut_out(f_out), .dut_oe(f_oe), .other_drive(other), .line(line),
        .dim_start(dim_start), .dim_out(dim));
    // =====================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] obs(input int sel);
        case (sel)
            0: return ch;
            1: return {10'h000, mode};
            2: return {11'h000, f_out & f_oe};
            3: return {11'h000, bus_if};
            4: return {11'h000, ede};
            5: return {11'h000, xseen};
            6: return {11'h000, pu};
            default: return {11'h000, otp};
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic note(input string name, input logic [11:0] exp, input int sel);
        notes.push_back('{name, exp, sel});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // =====================================================
    // Monitor: notes checked just after the falling edge that queued them,
    // before the next rising edge can act on stimulus changed there
    initial begin
        note_t n;
        forever begin
            @(negedge ref_clk);
            #10;
            while (notes.size() > 0) begin
                n = notes.pop_front();
                tests_run++;
                if (n.exp !== obs(n.sel)) begin
                    fails++;
                    $display("mismatch %s expected %h seen %h", n.name, n.exp, obs(n.sel));
                end
            end
        end
    end
    // Watchdog, far beyond the roughly 1100 cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
    // =====================================================
    // Main sequence
    initial begin
        rnd = lfsr(rnd);
        img_a = rnd[11:0];
        img_b = ~rnd[11:0];
        cyc(2);
        resetn = 1'b1;
        cyc(8);
        note("mode", 12'(PWR_STANDALONE), 1);
        note("image a", img_a, 0);
        force_b = 1'b1;
        cyc(8);
        note("force ignored", 12'(PWR_STANDALONE), 1);
        cfg = 1'b1;
        cyc(1);
        note("select synced", img_a, 0);
        cyc(7);
        note("image b", img_b, 0);
        $display("test standalone done");
        rnd = lfsr(rnd);
        en = rnd[11:0] | 12'h001;
        dsok = 1'b1;
        cyc(8);
        note("bus mode", 12'(PWR_BUS), 1);
        note("bus if", 12'h001, 3);
        note("bus enables", en, 0);
        note("pullup digital_supply", 12'h001, 6);
        cs = 1'b1;
        cyc(1);
        note("otp select", 12'h001, 7);
        cyc(1);
        cs = 1'b0;
        cyc(1);
        note("otp idle", 12'h000, 7);
        $display("test bus entry done");
        pg = 1'b1;
        cyc(600);
        note("detect early", 12'h000, 4);
        cyc(100);
        note("detect valid", 12'h001, 4);
        $display("test power good done");
        // Each source code with an open fault, then an overtemperature;
        // register dimming held off, yet an open fault must keep the flag high on every source but overtemperature
        pwm = 12'h000;
        for (int s = 0; s < 4; s++) begin
            fsel = 2'(s);
            open = 12'h001;
            otw = 1'b0;
            cyc(4);
            note("flag open", {11'h000, s != 1}, 2);
            note("pwm gate", 12'h000, 0);
            open = 12'h000;
            otw = 1'b1;
            cyc(4);
            note("flag ot", {11'h000, s == 1 || s == 2}, 2);
            note("no echo", 12'h000, 5);
        end
        otw = 1'b0;
        fsel = FLG_SRC_ERR;
        rsh = 1'b1;
        cyc(4);
        note("flag short", 12'h001, 2);
        rsh = 1'b0;
        fsel = FLG_SRC_BOTH;
        tsd = 1'b1;
        cyc(4);
        note("flag thermal", 12'h001, 2);
        note("thermal off", 12'h000, 0);
        tsd = 1'b0;
        fsel = FLG_SRC_ERR;
        $display("test flag sources done");
        gde = 1'b1;
        open = 12'h001;
        cyc(10);
        note("dim low", 12'h000, 0);
        dim_start = 1'b1;
        cyc(1);
        dim_start = 1'b0;
        cyc(149);
        note("wake wait", 12'h000, 0);
        cyc(15);
        note("dim on", en, 0);
        note("flag blink high", 12'h001, 2);
        cyc(100);
        note("dim off", 12'h000, 0);
        note("flag blink low", 12'h000, 2);
        gde = 1'b0;
        open = 12'h000;
        $display("test dimming done");
        xsd = 1'b1;
        cyc(4);
        note("line idle", 12'h000, 5);
        other = 1'b1;
        cyc(8);
        note("ext fault", 12'h001, 5);
        note("ext shutdown", 12'h000, 0);
        other = 1'b0;
        xsd = 1'b0;
        cyc(8);
        note("ext cleared", 12'h000, 5);
        $display("test external fault done");
        dsok = 1'b0;
        cyc(8);
        note("drop to standalone", 12'(PWR_STANDALONE), 1);
        note("drop image", img_b, 0);
        note("pullup ldo", 12'h000, 6);
        note("bus if off", 12'h000, 3);
        $display("test supply drop done");
        cyc(1);
        resetn = 1'b0;
        alowz = 1'b1;
        aok = 1'b0;
        dsok = 1'b1;
        cyc(2);
        resetn = 1'b1;
        cyc(10);
        note("if waits analog", 12'h000, 3);
        aok = 1'b1;
        cyc(4);
        note("if after analog", 12'h001, 3);
        $display("test low impedance done");
        cyc(3);
        end_of_test();
    end
endmodule
`default_nettype wire
